// File: hw/ppc_pad_cell.sv
`timescale 1ns/1ns
`default_nettype none
module ppc_pad_cell (
  // drive request
  input wire logic drive_en_i,
  input wire logic drive_val_i,
  input wire logic open_drain_i,
  // pad side
  output logic pad_out_o,
  output logic pad_oe_n_o
);

  // open drain only sinks; a high level is left to the pull-up
  always_comb begin
    pad_out_o = open_drain_i ? 1'b0 : drive_val_i;
    pad_oe_n_o = !(drive_en_i && (!open_drain_i || !drive_val_i));
  end

endmodule : ppc_pad_cell
`default_nettype wire

// File: hw/ppc_port_config.sv
// Overview of operation
// - port 5 pins 5,4 high-byte codes: input, pull-up input, none, output
// - port 5 low byte holds pins 3..0 with the same four codes
// - port 6 pins 5..3: input, reserved, lcd, output; high 7:4 unused
// - port 6 pin 2 code 01 drives serial data out onto the pin
// - port 6 pin 1 code 00 is input that feeds serial data in
// - port 6 pin 0: 00 shift clock in, 01 shift clock out, 10 lcd
// - port 6 pull-up enable register, one bit per pin, bits 7:6 unused
// - port 6 pull-up forced off for output, lcd, serial data out or shift clock out
// - port 6 output type register: 0 push-pull, 1 open-drain
`timescale 1ns/1ns
`default_nettype none
module ppc_port_config (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register access
  input wire ppc_pkg::ppc_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // port 5 pins
  input wire logic [ppc_pkg::PPC_PINS-1:0] p5_pin_i,
  input wire logic [ppc_pkg::PPC_PINS-1:0] p5_dout_i,
  output ppc_pkg::ppc_pad_t p5_pad_o,
  output logic [ppc_pkg::PPC_PINS-1:0] p5_din_o,
  // port 6 pins
  input wire logic [ppc_pkg::PPC_PINS-1:0] p6_pin_i,
  input wire logic [ppc_pkg::PPC_PINS-1:0] p6_dout_i,
  output ppc_pkg::ppc_pad_t p6_pad_o,
  output logic [ppc_pkg::PPC_PINS-1:0] p6_din_o,
  // lcd driver
  output logic [ppc_pkg::PPC_PINS-1:0] lcd_seg_en_o,
  // serial shifter
  input wire logic sio_so_i,
  input wire logic sio_sck_out_i,
  output logic sio_si_o,
  output logic sio_sck_in_o
);

  localparam int NP = ppc_pkg::PPC_PINS;
  localparam int CW = ppc_pkg::PPC_CODE_W;

  ////////////////////////////////////////////////////////////////////////////
  // state

  // pads idle released, serial inputs idle high
  localparam ppc_pkg::ppc_state_t STATE_RST = '{
    port5_high_pin_config: ppc_pkg::PPC_RST_CFG,
    port5_low_pin_config: ppc_pkg::PPC_RST_CFG,
    port6_high_pin_config: ppc_pkg::PPC_RST_CFG,
    port6_low_pin_config: ppc_pkg::PPC_RST_CFG,
    port6_pullup_enable: ppc_pkg::PPC_RST_CFG,
    port6_open_drain_select: ppc_pkg::PPC_RST_CFG,
    rdata: ppc_pkg::PPC_RDATA_NONE,
    p5: '{out: '0, oe_n: '1, pu: '0},
    p6: '{out: '0, oe_n: '1, pu: '0},
    lcd_en: '0,
    sdi: 1'b1,
    scki: 1'b1
  };

  ppc_pkg::ppc_state_t state_reg;
  ppc_pkg::ppc_state_t state_next;

  logic [ppc_pkg::PPC_CFG_W-1:0] cfg5;
  logic [ppc_pkg::PPC_CFG_W-1:0] cfg6;
  logic [ppc_pkg::PPC_SYNC_W-1:0] din_sync;
  logic [NP-1:0] din5;
  logic [NP-1:0] din6;
  logic [NP-1:0] drv_en5;
  logic [NP-1:0] drv_en6;
  logic [NP-1:0] drv_val6;
  logic [NP-1:0] pu5;
  logic [NP-1:0] pu6;
  logic [NP-1:0] lcd6;
  logic [NP-1:0] pad_out5;
  logic [NP-1:0] pad_oe_n5;
  logic [NP-1:0] pad_out6;
  logic [NP-1:0] pad_oe_n6;
  logic [NP-1:0] ods;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  ppc_sync u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({p6_pin_i, p5_pin_i}),
    .sync_o(din_sync)
  );

  assign din5 = din_sync[NP-1:0];
  assign din6 = din_sync[2*NP-1:NP];

  ////////////////////////////////////////////////////////////////////////////
  // per-pin decode

  // pin i field sits at bits 2i+1:2i of {high[3:0], low}
  assign cfg5 = {state_reg.port5_high_pin_config[3:0],
                 state_reg.port5_low_pin_config};
  assign cfg6 = {state_reg.port6_high_pin_config[3:0],
                 state_reg.port6_low_pin_config};
  assign ods = state_reg.port6_open_drain_select[NP-1:0];

  for (genvar i = 0; i < NP; i++) begin : g_pin
    logic [CW-1:0] c5;
    logic [CW-1:0] c6;
    logic alt_drv;
    assign c5 = cfg5[CW*i +: CW];
    assign c6 = cfg6[CW*i +: CW];
    // only the serial out and clock out pins have a driven alternate
    assign alt_drv = (i == ppc_pkg::PPC_SO_PIN) ||
                     (i == ppc_pkg::PPC_SCK_PIN);

    // code 10 on port 5 does nothing: pin stays a plain input
    assign drv_en5[i] = (c5 == ppc_pkg::PPC_P5_OUT);
    assign pu5[i] = (c5 == ppc_pkg::PPC_P5_IN_PU);

    assign drv_en6[i] = (c6 == ppc_pkg::PPC_P6_OUT) ||
                        ((c6 == ppc_pkg::PPC_P6_ALT) && alt_drv);
    // one continuous driver per bit keeps the vector single-sourced
    assign drv_val6[i] = (c6 != ppc_pkg::PPC_P6_ALT) ? p6_dout_i[i] :
      (i == ppc_pkg::PPC_SO_PIN) ? sio_so_i :
      sio_sck_out_i;
    // reserved code 01 counts as input, so its pull-up is kept
    assign pu6[i] = state_reg.port6_pullup_enable[i] &&
                    ((c6 == ppc_pkg::PPC_P6_IN) ||
                     ((c6 == ppc_pkg::PPC_P6_ALT) && !alt_drv));
    assign lcd6[i] = (c6 == ppc_pkg::PPC_P6_LCD);

    ppc_pad_cell u_pad5 (
      .drive_en_i(drv_en5[i]),
      .drive_val_i(p5_dout_i[i]),
      .open_drain_i(1'b0),
      .pad_out_o(pad_out5[i]),
      .pad_oe_n_o(pad_oe_n5[i])
    );

    ppc_pad_cell u_pad6 (
      .drive_en_i(drv_en6[i]),
      .drive_val_i(drv_val6[i]),
      .open_drain_i(ods[i]),
      .pad_out_o(pad_out6[i]),
      .pad_oe_n_o(pad_oe_n6[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_next = state_reg;
    // writes to unused bits are dropped so they read back zero, except port 5 high bits 7:4, which are stored and read back
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        ppc_pkg::PPC_ADDR_P5H: begin
          state_next.port5_high_pin_config =
            reg_req_i.wdata & ppc_pkg::PPC_MASK_FULL;
        end
        ppc_pkg::PPC_ADDR_P5L: begin
          state_next.port5_low_pin_config =
            reg_req_i.wdata & ppc_pkg::PPC_MASK_FULL;
        end
        ppc_pkg::PPC_ADDR_P6H: begin
          state_next.port6_high_pin_config =
            reg_req_i.wdata & ppc_pkg::PPC_MASK_P6H;
        end
        ppc_pkg::PPC_ADDR_P6L: begin
          state_next.port6_low_pin_config =
            reg_req_i.wdata & ppc_pkg::PPC_MASK_FULL;
        end
        ppc_pkg::PPC_ADDR_PUR: begin
          state_next.port6_pullup_enable =
            reg_req_i.wdata & ppc_pkg::PPC_MASK_PIN;
        end
        ppc_pkg::PPC_ADDR_ODS: begin
          state_next.port6_open_drain_select =
            reg_req_i.wdata & ppc_pkg::PPC_MASK_PIN;
        end
        default: begin
        end
      endcase
    end
    // a read in the same cycle as a write returns the old value
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        ppc_pkg::PPC_ADDR_P5H: state_next.rdata =
          state_reg.port5_high_pin_config;
        ppc_pkg::PPC_ADDR_P5L: state_next.rdata =
          state_reg.port5_low_pin_config;
        ppc_pkg::PPC_ADDR_P6H: state_next.rdata =
          state_reg.port6_high_pin_config;
        ppc_pkg::PPC_ADDR_P6L: state_next.rdata =
          state_reg.port6_low_pin_config;
        ppc_pkg::PPC_ADDR_PUR: state_next.rdata =
          state_reg.port6_pullup_enable;
        ppc_pkg::PPC_ADDR_ODS: state_next.rdata =
          state_reg.port6_open_drain_select;
        default: state_next.rdata = ppc_pkg::PPC_RDATA_NONE;
      endcase
    end
    state_next.p5.out = pad_out5;
    state_next.p5.oe_n = pad_oe_n5;
    state_next.p5.pu = pu5;
    state_next.p6.out = pad_out6;
    state_next.p6.oe_n = pad_oe_n6;
    state_next.p6.pu = pu6;
    state_next.lcd_en = lcd6;
    // serial inputs idle high when the pin is not in input mode
    state_next.sdi = (g_pin[ppc_pkg::PPC_SI_PIN].c6 == ppc_pkg::PPC_P6_IN) ?
      din6[ppc_pkg::PPC_SI_PIN] : 1'b1;
    state_next.scki = (g_pin[ppc_pkg::PPC_SCK_PIN].c6 == ppc_pkg::PPC_P6_IN) ?
      din6[ppc_pkg::PPC_SCK_PIN] : 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata_o = state_reg.rdata;
  assign p5_pad_o = state_reg.p5;
  assign p6_pad_o = state_reg.p6;
  assign p5_din_o = din5;
  assign p6_din_o = din6;
  assign lcd_seg_en_o = state_reg.lcd_en;
  assign sio_si_o = state_reg.sdi;
  assign sio_sck_in_o = state_reg.scki;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking ppc_clk @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  for (genvar i = 0; i < NP; i++) begin : g_chk
    if (i >= 4) begin : g_hi
      chk_p5_high_out: assert property (
        !$past(sys_rst_i) && $past(g_pin[i].c5) == ppc_pkg::PPC_P5_OUT
        |-> !p5_pad_o.oe_n[i] && p5_pad_o.out[i] == $past(p5_dout_i[i]))
        else $error("port 5 high pin not driving in output mode");
    end else begin : g_lo
      chk_p5_low_mode: assert property (
        !$past(sys_rst_i)
        |-> p5_pad_o.pu[i] == ($past(g_pin[i].c5) == ppc_pkg::PPC_P5_IN_PU)
            && p5_pad_o.oe_n[i] == ($past(g_pin[i].c5) != ppc_pkg::PPC_P5_OUT))
        else $error("port 5 low pin mode mismatch");
    end

    chk_p6_lcd_sel: assert property (
      !$past(sys_rst_i) && $past(g_pin[i].c6) == ppc_pkg::PPC_P6_LCD
      |-> lcd_seg_en_o[i] && p6_pad_o.oe_n[i] && !p6_pad_o.pu[i])
      else $error("lcd segment pin not released");

    chk_pull_enabled: assert property (
      !$past(sys_rst_i) && $past(g_pin[i].c6) == ppc_pkg::PPC_P6_IN
      |-> p6_pad_o.pu[i] == $past(state_reg.port6_pullup_enable[i]))
      else $error("port 6 pull-up does not follow enable");

    chk_pull_forced: assert property (
      !$past(sys_rst_i) && ($past(g_pin[i].c6) == ppc_pkg::PPC_P6_OUT
      || $past(g_pin[i].c6) == ppc_pkg::PPC_P6_LCD
      || ($past(g_pin[i].c6) == ppc_pkg::PPC_P6_ALT
          && (i == ppc_pkg::PPC_SO_PIN || i == ppc_pkg::PPC_SCK_PIN)))
      |-> !p6_pad_o.pu[i])
      else $error("pull-up on with output or alternate");

    chk_od_drive: assert property (
      !$past(sys_rst_i) && $past(g_pin[i].c6) == ppc_pkg::PPC_P6_OUT
      && $past(ods[i])
      |-> p6_pad_o.oe_n[i] == $past(p6_dout_i[i]) && !p6_pad_o.out[i])
      else $error("open-drain output drives high");
  end

  chk_so_route: assert property (
    !$past(sys_rst_i)
    && $past(g_pin[ppc_pkg::PPC_SO_PIN].c6) == ppc_pkg::PPC_P6_ALT
    && !$past(ods[ppc_pkg::PPC_SO_PIN])
    |-> !p6_pad_o.oe_n[ppc_pkg::PPC_SO_PIN]
        && p6_pad_o.out[ppc_pkg::PPC_SO_PIN] == $past(sio_so_i))
    else $error("serial data out not on its pin");

  chk_si_feed: assert property (
    !$past(sys_rst_i)
    && $past(g_pin[ppc_pkg::PPC_SI_PIN].c6) == ppc_pkg::PPC_P6_IN
    |-> sio_si_o == $past(p6_din_o[ppc_pkg::PPC_SI_PIN]))
    else $error("serial data in not fed from pin");

  chk_sck_paths: assert property (
    !$past(sys_rst_i)
    && $past(g_pin[ppc_pkg::PPC_SCK_PIN].c6) == ppc_pkg::PPC_P6_ALT
    && !$past(ods[ppc_pkg::PPC_SCK_PIN])
    |-> !p6_pad_o.oe_n[ppc_pkg::PPC_SCK_PIN]
        && p6_pad_o.out[ppc_pkg::PPC_SCK_PIN] == $past(sio_sck_out_i)
        && sio_sck_in_o)
    else $error("shift clock out not on its pin");

  chk_reset_clear: assert property (
    $past(sys_rst_i)
    |-> cfg5 == '0 && cfg6 == '0 && ods == '0 && p6_pad_o.pu == '0
        && p5_pad_o.oe_n == '1 && p6_pad_o.oe_n == '1)
    else $error("configuration not cleared by reset");

endmodule : ppc_port_config
`default_nettype wire

// File: hw/ppc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ppc_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // pin levels
  input wire logic [ppc_pkg::PPC_SYNC_W-1:0] async_i,
  output logic [ppc_pkg::PPC_SYNC_W-1:0] sync_o
);

  ppc_pkg::ppc_sync_state_t state_reg;
  ppc_pkg::ppc_sync_state_t state_next;

  // s1 feeds s2 only, never any logic
  always_comb begin
    state_next = state_reg;
    state_next.s1 = async_i;
    state_next.s2 = state_reg.s1;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.s2;

endmodule : ppc_sync
`default_nettype wire

// File: include/ppc_pkg.sv
`default_nettype none
package ppc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // geometry
  localparam int PPC_PINS = 6;
  localparam int PPC_CODE_W = 2;
  localparam int PPC_CFG_W = PPC_PINS * PPC_CODE_W;
  localparam int PPC_SYNC_W = 2 * PPC_PINS;

  // serial function pins on port 6
  localparam int PPC_SO_PIN = 2;
  localparam int PPC_SI_PIN = 1;
  localparam int PPC_SCK_PIN = 0;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [7:0] PPC_ADDR_P5H = 8'hf0;
  localparam logic [7:0] PPC_ADDR_P5L = 8'hf1;
  localparam logic [7:0] PPC_ADDR_P6H = 8'hf2;
  localparam logic [7:0] PPC_ADDR_P6L = 8'hf3;
  localparam logic [7:0] PPC_ADDR_PUR = 8'hf4;
  localparam logic [7:0] PPC_ADDR_ODS = 8'hf5;

  // implemented bits and reset values
  localparam logic [7:0] PPC_MASK_FULL = 8'hff;
  localparam logic [7:0] PPC_MASK_P6H = 8'h0f;
  localparam logic [7:0] PPC_MASK_PIN = 8'h3f;
  localparam logic [7:0] PPC_RST_CFG = 8'h00;
  localparam logic [7:0] PPC_RDATA_NONE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // pin codes
  typedef enum logic [1:0] {
    PPC_P5_IN = 2'b00,
    PPC_P5_IN_PU = 2'b01,
    PPC_P5_NONE = 2'b10,
    PPC_P5_OUT = 2'b11
  } ppc_p5_code_t;

  typedef enum logic [1:0] {
    PPC_P6_IN = 2'b00,
    PPC_P6_ALT = 2'b01,
    PPC_P6_LCD = 2'b10,
    PPC_P6_OUT = 2'b11
  } ppc_p6_code_t;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ppc_reg_req_t;

  typedef struct packed {
    logic [PPC_PINS-1:0] out;
    logic [PPC_PINS-1:0] oe_n;
    logic [PPC_PINS-1:0] pu;
  } ppc_pad_t;

  typedef struct packed {
    logic [7:0] port5_high_pin_config;
    logic [7:0] port5_low_pin_config;
    logic [7:0] port6_high_pin_config;
    logic [7:0] port6_low_pin_config;
    logic [7:0] port6_pullup_enable;
    logic [7:0] port6_open_drain_select;
    logic [7:0] rdata;
    ppc_pad_t p5;
    ppc_pad_t p6;
    logic [PPC_PINS-1:0] lcd_en;
    logic sdi;
    logic scki;
  } ppc_state_t;

  typedef struct packed {
    logic [PPC_SYNC_W-1:0] s1;
    logic [PPC_SYNC_W-1:0] s2;
  } ppc_sync_state_t;

endpackage : ppc_pkg
`default_nettype wire

// File: verification/ppc_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module ppc_pin_model (
  // clock
  input wire logic clk_i,
  // pad side of the design
  input wire ppc_pkg::ppc_pad_t pad_i,
  // outside drivers
  input wire logic [ppc_pkg::PPC_PINS-1:0] ext_en_i,
  input wire logic [ppc_pkg::PPC_PINS-1:0] ext_val_i,
  // resolved pin levels
  output logic [ppc_pkg::PPC_PINS-1:0] pin_o
);
  logic tgl = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // floating pins wander, so a stale level never passes for a drive
  always @(posedge clk_i) begin
    tgl <= ~tgl;
  end

  // pad drive wins, then outside drive, then the weak pull-up
  always_comb begin
    for (int i = 0; i < ppc_pkg::PPC_PINS; i++) begin
      if (!pad_i.oe_n[i]) begin
        pin_o[i] = pad_i.out[i];
      end else if (ext_en_i[i]) begin
        pin_o[i] = ext_val_i[i];
      end else if (pad_i.pu[i]) begin
        pin_o[i] = 1'b1;
      end else begin
        pin_o[i] = tgl ^ i[0];
      end
    end
  end
endmodule : ppc_pin_model
`default_nettype wire

// File: verification/ppc_port_config_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ppc_port_config_bench;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } ppc_row_t;

  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  ppc_pkg::ppc_reg_req_t req = '0;
  logic [7:0] rdata;
  logic [5:0] p5_pin, p5_din, p6_pin, p6_din, lcd_en;
  logic [5:0] p5_dout = '0;
  logic [5:0] p6_dout = '0;
  logic [5:0] p5_ext_en = '0;
  logic [5:0] p5_ext_val = '0;
  logic [5:0] p6_ext_en = '0;
  logic [5:0] p6_ext_val = '0;
  ppc_pkg::ppc_pad_t p5_pad, p6_pad;
  logic so = 1'b0;
  logic sck_out = 1'b0;
  logic si, sck_in;
  int num_errors = 0;
  int compares = 0;
  // unused bits of f2, f4, f5 drop; unmapped e0 reads zero
  ppc_row_t rows [7] = '{'{8'hf0, 8'hff, 8'hff}, '{8'hf1, 8'ha5, 8'ha5},
    '{8'hf2, 8'hff, 8'h0f}, '{8'hf3, 8'h5a, 8'h5a}, '{8'hf4, 8'hff, 8'h3f},
    '{8'hf5, 8'hff, 8'h3f}, '{8'he0, 8'hff, 8'h00}};

  always #5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  ppc_port_config ppc_port_config_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .p5_pin_i(p5_pin), .p5_dout_i(p5_dout),
    .p5_pad_o(p5_pad), .p5_din_o(p5_din), .p6_pin_i(p6_pin),
    .p6_dout_i(p6_dout), .p6_pad_o(p6_pad), .p6_din_o(p6_din),
    .lcd_seg_en_o(lcd_en), .sio_so_i(so), .sio_sck_out_i(sck_out),
    .sio_si_o(si), .sio_sck_in_o(sck_in)
  );
  ppc_pin_model ppc_pin_model_p5_inst (
    .clk_i(clk_i), .pad_i(p5_pad), .ext_en_i(p5_ext_en),
    .ext_val_i(p5_ext_val), .pin_o(p5_pin)
  );
  ppc_pin_model ppc_pin_model_inst (
    .clk_i(clk_i), .pad_i(p6_pad), .ext_en_i(p6_ext_en),
    .ext_val_i(p6_ext_val), .pin_o(p6_pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask : tick

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // strobe drops a cycle later so back-to-back calls never clash
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick();
    req.wr = 1'b0;
    tick();
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick();
    req.rd = 1'b0;
    d = rdata;
    tick();
  endtask : reg_rd

  // serial inputs checked at once, before the synchroniser catches up
  task automatic check_reset();
    logic [7:0] d;
    check(si, 8'h01);
    check(sck_in, 8'h01);
    check(p6_pad.oe_n, 8'h3f);
    check(p6_pad.pu, 8'h00);
    check(p5_pad.oe_n, 8'h3f);
    check(lcd_en, 8'h00);
    for (int a = 8'hf0; a <= 8'hf5; a++) begin
      reg_rd(a[7:0], d);
      check(d, 8'h00);
    end
  endtask : check_reset

  task automatic report_and_stop();
    $display("compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) tick();
    num_errors++;
    report_and_stop();
  end

  initial begin
    logic [7:0] d;
    repeat (2) tick();
    sys_rst_i = 1'b0;
    check_reset();
    foreach (rows[i]) begin
      reg_wr(rows[i].addr, rows[i].wdata);
      reg_rd(rows[i].addr, d);
      check(d, rows[i].rexp);
    end
    // port 5: pin4, pin3 drive, pin2 unavailable, pin1 pull-up, pin0 low
    p5_dout = 6'h3f;
    p5_ext_en = 6'h01;
    reg_wr(8'hf0, 8'h03);
    reg_wr(8'hf1, 8'he4);
    check(p5_pad.oe_n, 8'h27);
    check(p5_pad.out & 6'h18, 8'h18);
    check(p5_pad.pu, 8'h02);
    repeat (2) tick();
    check(p5_din & 6'h1b, 8'h1a);
    p5_dout = 6'h10;
    tick();
    check(p5_pad.out & 6'h18, 8'h10);
    // port 6: pin5 out, pin4 lcd, pin3 reserved, pin2 so, pin1 si, pin0 sck
    p6_dout = 6'h3f;
    so = 1'b1;
    p6_ext_en = 6'h02;
    reg_wr(8'hf4, 8'hff);
    reg_wr(8'hf5, 8'h00);
    reg_wr(8'hf2, 8'h0e);
    reg_wr(8'hf3, 8'h51);
    check(p6_pad.oe_n, 8'h1a);
    check(p6_pad.out & 6'h25, 8'h24);
    check(p6_pad.pu, 8'h0a);
    check(lcd_en, 8'h10);
    check(si, 8'h00);
    check(sck_in, 8'h01);
    so = 1'b0;
    sck_out = 1'b1;
    p6_ext_val = 6'h02;
    tick();
    check(p6_pad.out & 6'h25, 8'h21);
    repeat (2) tick();
    check(si, 8'h01);
    check(p6_din & 6'h02, 8'h02);
    // pin0 back to shift clock input, driven low from outside
    // pad lets go one edge after the write, then two sync flops and scki
    p6_ext_en = 6'h03;
    reg_wr(8'hf3, 8'h50);
    repeat (3) tick();
    check(sck_in, 8'h00);
    check(p6_pad.pu, 8'h0b);
    // open drain on pins 5, 2, 0: highs release, lows pull down
    so = 1'b1;
    sck_out = 1'b0;
    reg_wr(8'hf3, 8'h51);
    reg_wr(8'hf5, 8'h25);
    check(p6_pad.oe_n, 8'h3e);
    check(p6_pad.out & 6'h01, 8'h00);
    so = 1'b0;
    tick();
    check(p6_pad.oe_n, 8'h3a);
    p6_dout = 6'h00;
    tick();
    check(p6_pad.oe_n, 8'h1a);
    check(p6_pad.out & 6'h25, 8'h00);
    // reset in mid-run clears everything again
    sys_rst_i = 1'b1;
    tick();
    sys_rst_i = 1'b0;
    check_reset();
    report_and_stop();
  end
endmodule : ppc_port_config_bench
`default_nettype wire
